// ---- design/lcd_channel.sv ----
// one line channel: drive monitor, tx enable, fifo, pattern, loops
`timescale 1ns/1ps
`include "lcd_params.svh"
module lcd_channel import lcd_pkg::*; (
    input wire logic clk_sys, // system clock, 40 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic tx_line_clock, // transmit clock pin
    input wire logic recovered_clock, // recovered receive clock
    input wire logic dejitter_clock, // smoothed clock for fifo reads
    input wire logic tx_pos_data, // framer positive rail
    input wire logic tx_neg_data, // framer negative rail
    input wire logic transmit_on_pin, // shared transmit-on pin
    input wire logic monitor_pos_in, // monitor tap, positive
    input wire logic monitor_neg_in, // monitor tap, negative
    input wire logic line_rx_pos, // line receive, positive
    input wire logic line_rx_neg, // line receive, negative
    output logic line_tx_pos, // line transmit, positive
    output logic line_tx_neg, // line transmit, negative
    output logic line_tx_oe, // line driver enable, high drives
    output logic drive_fault_out, // high when tx line silent
    output logic rx_clock_out, // receive clock to framer
    output logic rx_pos_data, // receive positive rail
    output logic rx_neg_violation_out // rx negative rail or violation
);

    // ========================================
    // input synchronisers
    logic [9:0] sync1; // first stage, read by sync2 only
    logic [9:0] sync2; // settled copies
    logic [4:0] prev; // last settled clocks and monitors
    logic [8:0] ctrl; // control register
    logic ins_prev; // insert bit one cycle ago

    // two flops before any logic looks at pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 10'h000;
            sync2 <= 10'h000;
            prev <= 5'h00;
        end else begin
            sync1 <= {transmit_on_pin, line_rx_neg, line_rx_pos,
                      tx_neg_data, tx_pos_data, monitor_neg_in,
                      monitor_pos_in, dejitter_clock, recovered_clock,
                      tx_line_clock};
            sync2 <= sync1;
            prev <= sync2[4:0];
        end
    end

    // rising edges of the three link clocks
    wire tx_edge = sync2[`LCD_S_TXCLK] & ~prev[`LCD_S_TXCLK];
    wire rx_edge = sync2[`LCD_S_RXCLK] & ~prev[`LCD_S_RXCLK];
    wire dj_edge = sync2[`LCD_S_DJCLK] & ~prev[`LCD_S_DJCLK];

    // ========================================
    // control decode
    wire pattern_enable = ctrl[`LCD_C_PAT];
    wire e3_rate = ctrl[`LCD_C_E3];
    wire jitter_path_select = ctrl[`LCD_C_JPATH];
    wire [1:0] loop_bits = {ctrl[`LCD_C_RLB], ctrl[`LCD_C_LLB]};
    wire [1:0] cfg_bits = {ctrl[`LCD_C_CFG1], ctrl[`LCD_C_CFG0]};
    lcd_loop_t loop_mode;
    lcd_ja_t ja_mode;
    // loop encoding: remote bit high, local bit low
    assign loop_mode = (loop_bits == 2'h1) ? LCD_LOOP_ANALOG :
                       (loop_bits == 2'h2) ? LCD_LOOP_REMOTE :
                       (loop_bits == 2'h3) ? LCD_LOOP_DIGITAL :
                       LCD_LOOP_NORMAL;
    // depth encoding; both set picks the deep fifo
    assign ja_mode = (cfg_bits == 2'h0) ? LCD_JA_OFF :
                     (cfg_bits == 2'h1) ? LCD_JA_16 :
                     LCD_JA_32;
    wire ja_on = (ja_mode != LCD_JA_OFF);
    wire ja_rx = ja_on & ~jitter_path_select;
    wire ja_tx = ja_on & jitter_path_select;
    wire is_analog = (loop_mode == LCD_LOOP_ANALOG);
    wire is_remote = (loop_mode == LCD_LOOP_REMOTE);
    wire is_digital = (loop_mode == LCD_LOOP_DIGITAL);
    wire [5:0] depth = (ja_mode == LCD_JA_16) ? `LCD_FIFO_SMALL :
                       `LCD_FIFO_LARGE;

    // ========================================
    // apb decode
    wire setup_ok = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire hit_ctrl = (paddr == `LCD_CTRL_OFS);
    wire hit_stat = (paddr == `LCD_STAT_OFS);
    wire wr_ctrl = done & pwrite & hit_ctrl;
    wire rd_stat = done & ~pwrite & hit_stat;
    logic fifo_limit_flag; // near-limit sticky flag
    logic locked; // checker in sync
    logic tx_enable; // transmitter on
    logic [31:0] next_rdata;
    wire pattern_sync_lost = pattern_enable & ~locked;
    assign next_rdata = hit_ctrl ? {23'h000000, ctrl} :
                        hit_stat ? {28'h0000000, tx_enable,
                                    drive_fault_out, pattern_sync_lost,
                                    fifo_limit_flag} :
                        32'h00000000;

    // one wait state: ready and data come from flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ok;
            pslverr <= setup_ok & ~hit_ctrl & ~hit_stat;
            prdata <= setup_ok ? next_rdata : 32'h00000000;
        end
    end

    // control register; status offset ignores writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `LCD_CTRL_RST;
            ins_prev <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata[8:0];
            end
            ins_prev <= ctrl[`LCD_C_INS];
        end
    end

    // ========================================
    // transmitter enable
    // both must agree; once the bit is 1 the pin alone switches
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_enable <= 1'b0;
        end else begin
            tx_enable <= sync2[`LCD_S_TXPIN] & ctrl[`LCD_C_TRANSMIT_ON_PIN];
        end
    end

    // ========================================
    // drive monitor
    logic [7:0] dm_count; // tx periods since last transition
    wire mon_change = (sync2[`LCD_S_MONP] != prev[`LCD_S_MONP]) |
                      (sync2[`LCD_S_MONN] != prev[`LCD_S_MONN]);

    // any transition clears the count; saturates at the limit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dm_count <= 8'h00;
            drive_fault_out <= 1'b0;
        end else if (mon_change) begin
            dm_count <= 8'h00;
            drive_fault_out <= 1'b0;
        end else begin
            if (tx_edge && dm_count != `LCD_DM_LIMIT) begin
                dm_count <= dm_count + 8'h01;
            end
            drive_fault_out <= (dm_count == `LCD_DM_LIMIT);
        end
    end

    // ========================================
    // pattern generator
    logic [22:0] gen_lfsr; // generator shift register
    logic ins_pending; // one error waiting to go out
    wire gen_fb = e3_rate ? (gen_lfsr[22] ^ gen_lfsr[17]) :
                  (gen_lfsr[14] ^ gen_lfsr[13]);
    wire gen_bit = gen_fb ^ ins_pending;
    wire gen_step = tx_edge & pattern_enable & ~is_remote;
    wire ins_rise = ctrl[`LCD_C_INS] & ~ins_prev;

    // all-ones seed keeps the register out of lock-up
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gen_lfsr <= 23'h7FFFFF;
            ins_pending <= 1'b0;
        end else begin
            if (gen_step) begin
                gen_lfsr <= {gen_lfsr[21:0], gen_fb};
            end
            // a fresh edge wins over the consuming step
            ins_pending <= (ins_rise & pattern_enable) |
                           (ins_pending & ~gen_step);
        end
    end

    // ========================================
    // data routing
    logic [1:0] rx_line; // receive line, after analog loop mux
    logic [1:0] fifo_out; // word at the read pointer
    logic [1:0] tx_src; // transmit source word
    logic [1:0] rx_stage; // receive word after optional fifo
    logic [1:0] wr_data; // fifo write word
    logic [1:0] tx_word; // word headed for the line
    logic rd_evt; // fifo read strobe
    // analog loop takes our own line drive, ignores rx pins
    assign rx_line = is_analog ? {line_tx_neg, line_tx_pos} :
                     {sync2[`LCD_S_RXN], sync2[`LCD_S_RXP]};
    wire rx_stage_evt = ja_rx ? rd_evt : rx_edge;
    assign rx_stage = ja_rx ? fifo_out : rx_line;
    // remote loop retimes on the receive side, tx pins unused
    wire tx_src_evt = is_remote ? rx_stage_evt : tx_edge;
    assign tx_src = is_remote ? rx_stage :
                    pattern_enable ? {1'b0, gen_bit} :
                    {sync2[`LCD_S_TXN], sync2[`LCD_S_TXP]};
    wire wr_evt = ja_on & (ja_rx ? rx_edge : tx_src_evt);
    assign wr_data = ja_rx ? rx_line : tx_src;
    wire tx_evt = ja_tx ? rd_evt : tx_src_evt;
    assign tx_word = ja_tx ? fifo_out : tx_src;

    // ========================================
    // attenuator fifo
    logic [1:0] fifo_mem [0:31]; // two rails per entry
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [5:0] fifo_count; // entries held
    logic primed; // half full once, reads may start
    wire fifo_clear = rd_stat | ~ja_on;
    wire do_wr = wr_evt & (fifo_count != depth);
    assign rd_evt = dj_edge & ja_on & primed & (fifo_count != 6'h00);
    assign fifo_out = fifo_mem[rd_ptr];
    wire [4:0] ptr_mask = 5'(depth - 6'h01);
    wire near_limit = primed &
                      ((fifo_count >= depth - `LCD_FIFO_MARGIN) |
                       (fifo_count <= `LCD_FIFO_MARGIN));

    // storage array, written only on the path clock event
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            fifo_mem[wr_ptr] <= wr_data;
        end
    end

    // pointers wrap at the chosen depth
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 5'h00;
            rd_ptr <= 5'h00;
            fifo_count <= 6'h00;
            primed <= 1'b0;
        end else if (fifo_clear) begin
            wr_ptr <= 5'h00;
            rd_ptr <= 5'h00;
            fifo_count <= 6'h00;
            primed <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr + 5'h01) & ptr_mask;
            end
            if (rd_evt) begin
                rd_ptr <= (rd_ptr + 5'h01) & ptr_mask;
            end
            fifo_count <= fifo_count + {5'h00, do_wr} -
                          {5'h00, rd_evt};
            if (fifo_count >= (depth >> 1)) begin
                primed <= 1'b1;
            end
        end
    end

    // sticky flag; the clearing read also empties the fifo, so a
    // near-limit seen on that edge belongs to discarded contents
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fifo_limit_flag <= 1'b0;
        end else begin
            fifo_limit_flag <= (near_limit & ~fifo_clear) |
                               (fifo_limit_flag & ~rd_stat);
        end
    end

    // ========================================
    // line transmit outputs
    // enable follows tx_enable in every loop mode, analog included; off floats via enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_tx_pos <= 1'b0;
            line_tx_neg <= 1'b0;
            line_tx_oe <= 1'b0;
        end else begin
            if (tx_evt) begin
                line_tx_pos <= tx_word[0];
                line_tx_neg <= tx_word[1];
            end
            line_tx_oe <= tx_enable;
        end
    end

    // ========================================
    // pattern checker
    logic [22:0] chk_hist; // received bit history
    logic [5:0] good_count; // matches in a row
    logic [2:0] bad_count; // errors since lock
    logic err_pulse; // held until next rx bit
    wire chk_bit = rx_stage[0] | rx_stage[1];
    wire chk_pred = e3_rate ? (chk_hist[22] ^ chk_hist[17]) :
                    (chk_hist[14] ^ chk_hist[13]);
    wire chk_err = chk_bit ^ chk_pred;
    wire chk_step = rx_stage_evt & pattern_enable;

    // self-synchronising: history is the received stream
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chk_hist <= 23'h000000;
            good_count <= 6'h00;
            bad_count <= 3'h0;
            locked <= 1'b0;
            err_pulse <= 1'b0;
        end else if (!pattern_enable) begin
            good_count <= 6'h00;
            bad_count <= 3'h0;
            locked <= 1'b0;
            err_pulse <= 1'b0;
        end else if (chk_step) begin
            chk_hist <= {chk_hist[21:0], chk_bit};
            err_pulse <= chk_err & locked;
            if (chk_err) begin
                good_count <= 6'h00;
                bad_count <= bad_count + 3'h1;
                if (bad_count == `LCD_LOSS_BAD - 3'h1) begin
                    locked <= 1'b0;
                end
            end else if (good_count != `LCD_LOCK_GOOD) begin
                good_count <= good_count + 6'h01;
            end else begin
                locked <= 1'b1;
                bad_count <= 3'h0;
            end
        end
    end

    // ========================================
    // receive outputs to the framer
    wire rx_src_clk = ja_rx ? sync2[`LCD_S_DJCLK] :
                      sync2[`LCD_S_RXCLK];
    wire rx_out_evt = is_digital ? tx_edge : rx_stage_evt;
    wire [1:0] rx_out_word = is_digital ?
                             {sync2[`LCD_S_TXN], sync2[`LCD_S_TXP]} :
                             rx_stage;

    // in pattern mode the negative rail shows sync and errors
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_clock_out <= 1'b0;
            rx_pos_data <= 1'b0;
            rx_neg_violation_out <= 1'b0;
        end else begin
            rx_clock_out <= is_digital ? sync2[`LCD_S_TXCLK] :
                            rx_src_clk;
            if (rx_out_evt) begin
                rx_pos_data <= pattern_enable ? chk_bit :
                               rx_out_word[0];
            end
            if (pattern_enable) begin
                rx_neg_violation_out <= ~locked | err_pulse;
            end else if (rx_out_evt) begin
                rx_neg_violation_out <= rx_out_word[1];
            end
        end
    end

endmodule

// ---- design/lcd_params.svh ----
// constants for the line channel diagnostics block
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

// ========================================
// register byte offsets and control reset value
`define LCD_CTRL_OFS 12'h000
`define LCD_STAT_OFS 12'h004
`define LCD_CTRL_RST 9'h000

// ========================================
// control register field positions
`define LCD_C_TRANSMIT_ON_PIN 0
`define LCD_C_JPATH 1
`define LCD_C_CFG0 2
`define LCD_C_CFG1 3
`define LCD_C_PAT 4
`define LCD_C_INS 5
`define LCD_C_RLB 6
`define LCD_C_LLB 7
`define LCD_C_E3 8

// ========================================
// synchroniser bit positions
`define LCD_S_TXCLK 0
`define LCD_S_RXCLK 1
`define LCD_S_DJCLK 2
`define LCD_S_MONP 3
`define LCD_S_MONN 4
`define LCD_S_TXP 5
`define LCD_S_TXN 6
`define LCD_S_RXP 7
`define LCD_S_RXN 8
`define LCD_S_TXPIN 9

// ========================================
// timing and sizing counts
`define LCD_DM_LIMIT 8'h80
`define LCD_FIFO_SMALL 6'h10
`define LCD_FIFO_LARGE 6'h20
`define LCD_FIFO_MARGIN 6'h02
`define LCD_LOCK_GOOD 6'h20
`define LCD_LOSS_BAD 3'h4

`endif

// ---- design/lcd_pkg.sv ----
// types for the line channel diagnostics block
package lcd_pkg;
    // loopback routing of one channel
    typedef enum logic [1:0] {
        LCD_LOOP_NORMAL,
        LCD_LOOP_ANALOG,
        LCD_LOOP_REMOTE,
        LCD_LOOP_DIGITAL
    } lcd_loop_t;
    // attenuator fifo depth choice
    typedef enum logic [1:0] {
        LCD_JA_OFF,
        LCD_JA_16,
        LCD_JA_32
    } lcd_ja_t;
endpackage

// ---- verification/lcd_channel_props.sv ----
// assertions for the line channel diagnostics block
`timescale 1ns/1ps
`include "lcd_params.svh"
module lcd_channel_props (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic transmit_on_pin, // shared enable pin
    input wire logic monitor_pos_in, // monitor tap, positive
    input wire logic monitor_neg_in, // monitor tap, negative
    input wire logic line_tx_oe, // line driver enable
    input wire logic drive_fault_out // silent line flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ========================================
    // monitor quiet time in system clocks
    logic [1:0] mon_q; // taps one cycle ago
    logic [10:0] quiet; // saturates, never wraps into a false low
    logic mon_chg; // either tap moved
    assign mon_chg = {monitor_pos_in, monitor_neg_in} != mon_q;
    // count since the last tap change
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mon_q <= 2'h0;
            quiet <= 11'h000;
        end else begin
            mon_q <= {monitor_pos_in, monitor_neg_in};
            quiet <= mon_chg ? 11'h000 : quiet + {10'h000, ~&quiet};
        end
    end
    // ========================================
    // bus handshake
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_READY_AFTER_ACCESS: assert property (psel && penable && !pready
        |=> pready) else $error("no ready after access phase");
    AST_ERR_DECODE: assert property (psel && penable && !pready |=>
        pslverr == ($past(paddr) != `LCD_CTRL_OFS &&
        $past(paddr) != `LCD_STAT_OFS)) else $error("bad error decode");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside transfer");
    // ========================================
    // transmitter enable and drive monitor
    AST_TX_OFF_FLOAT: assert property (
        !transmit_on_pin [*6] |-> !line_tx_oe)
        else $error("driver enabled with pin low");
    AST_FAULT_NEEDS_QUIET: assert property (
        $rose(drive_fault_out) |-> quiet >= 11'h300)
        else $error("fault raised while line active");
    AST_FAULT_BY_LIMIT: assert property (
        quiet == 11'h578 |-> drive_fault_out)
        else $error("fault missing after long silence");
    AST_FAULT_CLEARS: assert property (
        drive_fault_out && mon_chg |-> ##[1:6] !drive_fault_out)
        else $error("fault did not clear on transitions");
    // main scenarios reached
    cover property (pslverr);
    cover property ($rose(drive_fault_out));
    cover property ($fell(line_tx_oe));
endmodule
bind lcd_channel lcd_channel_props lcd_channel_props_inst (.clk_sys,
    .rst_n, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .transmit_on_pin, .monitor_pos_in, .monitor_neg_in, .line_tx_oe,
    .drive_fault_out);

// ---- verification/lcd_framer_model.sv ----
// framer model on the system side: sends rails on the transmit clock
`timescale 1ns/1ps
module lcd_framer_model (
    input wire logic tx_line_clock, // bit clock
    input wire logic [1:0] mode, // 0 spaces, 1 marks, 2 random
    output logic tx_pos_data, // positive rail
    output logic tx_neg_data // negative rail
);
    int seed = 5; // fixed so runs repeat
    logic [31:0] r; // fresh draw per bit
    initial begin
        tx_pos_data = 1'b0;
        tx_neg_data = 1'b0;
    end
    // change on the fall, half a bit away from the sampling rise
    always @(negedge tx_line_clock) begin
        r = $random(seed);
        tx_pos_data <= mode == 2'd1 || (mode == 2'd2 && r[0]);
        // never both rails at once, as a real line coder
        tx_neg_data <= mode == 2'd2 && !r[0] && r[1];
    end
endmodule

// ---- verification/tb.sv ----
// self-checking testbench for the line channel diagnostics block
`timescale 1ns/1ps
`include "lcd_params.svh"
module tb;
    // ========================================
    // signals
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr; // apb address
    logic [31:0] pwdata, prdata, rd, rnd; // bus data, last read, draw
    logic tx_line_clock, recovered_clock, dejitter_clock, tx_pos_data;
    logic tx_neg_data, transmit_on_pin, monitor_pos_in, monitor_neg_in;
    logic line_rx_pos, line_rx_neg, line_tx_pos, line_tx_neg, line_tx_oe;
    logic drive_fault_out, rx_clock_out, rx_pos_data, rx_neg_violation_out;
    logic err, rx_rand, dj_run, neg_seen; // bench controls
    logic [1:0] fmode, e; // framer mode, loop expectation
    int num_errors = 0, checks_done = 0, seed = 5, cycles = 0, viol, n1;
    lcd_channel lcd_channel_inst (.clk_sys, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tx_line_clock, .recovered_clock, .dejitter_clock, .tx_pos_data,
        .tx_neg_data, .transmit_on_pin, .monitor_pos_in, .monitor_neg_in,
        .line_rx_pos, .line_rx_neg, .line_tx_pos, .line_tx_neg, .line_tx_oe,
        .drive_fault_out, .rx_clock_out, .rx_pos_data, .rx_neg_violation_out);
    lcd_framer_model lcd_framer_model_inst (.tx_line_clock, .mode(fmode),
        .tx_pos_data, .tx_neg_data);
    // ========================================
    // clocks: transmit and recovered clocks free-running, phases unrelated to clk_sys
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        tx_line_clock = 1'b0;
        #13 forever #100 tx_line_clock = ~tx_line_clock;
    end
    initial begin
        recovered_clock = 1'b0;
        #61 forever #100 recovered_clock = ~recovered_clock;
    end
    // smoothed clock can be stopped to fill the fifo
    assign dejitter_clock = tx_line_clock & dj_run;
    // taps through the line resistors; a floating line reads low
    assign monitor_pos_in = line_tx_oe & line_tx_pos;
    assign monitor_neg_in = line_tx_oe & line_tx_neg;
    // far line: random bits or a fixed space/mark pair
    always @(negedge recovered_clock) begin
        rnd = $random(seed);
        line_rx_pos <= rx_rand & rnd[0];
        line_rx_neg <= rx_rand ? rnd[1] & !rnd[0] : 1'b1;
    end
    always @(posedge rx_neg_violation_out) viol++;
    always @(posedge line_tx_neg) neg_seen = 1'b1;
    // hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            complete_run();
        end
    end
    // ========================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one apb transfer, holds the request until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 40) chk("pready wait", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // {line tx pos, rx pos} with framer marks and line spaces
    function automatic logic [1:0] loop_exp(input logic [1:0] k);
        return {k != 2'b10, k[0]};
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {transmit_on_pin, line_rx_pos, line_rx_neg, rx_rand} = '0;
        {fmode, neg_seen, err, rd, dj_run} = 1;
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b0, `LCD_CTRL_OFS, 32'h0);
        chk("ctrl reset", rd, {23'h0, `LCD_CTRL_RST});
        $display("test registers done");
        // pin and bit pairs, then pin alone once the bit is set
        for (int i = 0; i < 6; i++) begin
            transmit_on_pin <= i[0];
            apb(1'b1, `LCD_CTRL_OFS, 32'(i > 1));
            tick(8);
            chk("tx enable", 32'(line_tx_oe), 32'(i[0] && i > 1));
        end
        $display("test transmit enable done");
        fmode <= 2'd1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `LCD_CTRL_OFS, {24'h0, k[0], k[1], 6'h01});
            tick(40);
            e = loop_exp(k[1:0]);
            chk("loop pins", {line_tx_oe, line_tx_pos, line_tx_neg, rx_pos_data,
                rx_neg_violation_out}, {1'b1, e[1], !e[1], e[0], !e[0]});
            // looked at where the two clock copies differ in level
            @(negedge tx_line_clock);
            tick(4);
            chk("rx clock", 32'(rx_clock_out), 32'(k != 3));
        end
        $display("test loopbacks done");
        fmode <= 2'd2;
        dj_run <= 1'b0;
        // sweep includes the short depth that suits latency
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `LCD_CTRL_OFS, {28'h0, c[1:0], c[2], 1'b1});
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            tick(176);
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            chk("fifo flag short", 32'(rd[0]), 32'(c[1:0] == 2'd1));
            tick(320);
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            chk("fifo flag long", 32'(rd[0]), 32'(c[1:0] != 2'd0));
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            chk("fifo flag cleared", 32'(rd[0]), 32'h0);
        end
        dj_run <= 1'b1;
        $display("test fifo done");
        apb(1'b1, `LCD_CTRL_OFS, 32'h1);
        tick(600);
        chk("fault active line", 32'(drive_fault_out), 32'h0);
        fmode <= 2'd0;
        tick(1500);
        apb(1'b0, `LCD_STAT_OFS, 32'h0);
        chk("fault silent", {drive_fault_out, rd[2]}, 32'h3);
        fmode <= 2'd2;
        tick(80);
        chk("fault cleared", 32'(drive_fault_out), 32'h0);
        $display("test drive monitor done");
        rx_rand <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'h11});
            tick(800);
            neg_seen = 1'b0;
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            chk("out of sync", {rd[1], rx_neg_violation_out}, 32'h3);
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'h91});
            tick(800);
            apb(1'b0, `LCD_STAT_OFS, 32'h0);
            chk("locked", {rd[1], rx_neg_violation_out}, 32'h0);
            viol = 0;
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'hB1});
            tick(400);
            n1 = viol;
            chk("error pulses", 32'(n1 > 0), 32'h1);
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'hB1});
            tick(400);
            chk("no rewrite insert", viol, n1);
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'h91});
            apb(1'b1, `LCD_CTRL_OFS, {23'h0, r[0], 8'hB1});
            tick(400);
            chk("second insert", viol, 2 * n1);
            chk("single rail", 32'(neg_seen), 32'h0);
        end
        $display("test pattern done");
        complete_run();
    end
endmodule
